// ---- rtl/pwm_pin.sv ----
// one pwm pin: high on A match, low on B match
// assumes match pulses are one cycle each
module pwm_pin (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // control
  input  wire logic enable,
  input  wire logic match_a,
  input  wire logic match_b,
  // result
  output logic      level_ff
);
  logic nxt_level;

  always_comb begin
    nxt_level = level_ff;
    if (!enable) begin
      nxt_level = 1'b0;
    end else if (match_b) begin
      nxt_level = 1'b0;
    end else if (match_a) begin
      nxt_level = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
    end
  end
endmodule // pwm_pin

// ---- rtl/timer_mode_function_control.sv ----
// mode, buffering, phase counting and output enable control
// assumes synchronous inputs and a one-cycle read data port
`include "tmfc_defs.svh"
module timer_mode_function_control (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    standby,
  // register port
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [7:0]              rdata_ff,
  // counter and compare events
  input  wire tmfc_pkg::timer_events_s events,
  input  wire logic [3:0]              is_capture,
  input  wire logic                    ext_clock_in_a,
  input  wire logic                    ext_clock_in_b,
  input  wire logic                    counter_ch2_run,
  // buffer pair transfers
  output logic      [3:0]              buf_to_gen_ff,
  output logic      [3:0]              gen_to_buf_ff,
  // pins, modes, channel 2 counter and overflow flag
  output tmfc_pkg::pin_out_s           pins_ff,
  output logic      [1:0]              comb_mode_ff,
  output logic      [1:0]              sync_34_ff,
  output logic      [15:0]             counter_ch2_ff,
  output logic                         overflow_flag_ff
);
  logic [7:0]  mode_ff;
  logic [7:0]  func_ff;
  logic [7:0]  out_en_ff;
  logic [7:0]  out_ctrl_ff;
  logic [7:0]  sync_ff;
  logic        clk_a_ff;
  logic        clk_b_ff;
  logic        combined;
  logic        trigger;
  logic        rst;
  logic        wr_mode;
  logic        wr_func;
  logic        wr_en;
  logic        step_up;
  logic        step_dn;
  logic        edge_a;
  logic        edge_b;
  logic [4:0]  pwm_sel;
  logic [4:0]  pwm_lvl;
  logic [7:0]  nxt_rdata;
  logic [15:0] nxt_count;
  logic        over_ev;
  logic        unf_ev;
  tmfc_pkg::comb_mode_e comb;
  tmfc_pkg::ch2_state_e ch2_state;

  assign rst     = !resetn || standby;
  assign wr_mode = wr_stb && (addr == `ADDR_MODE);
  assign wr_func = wr_stb && (addr == `ADDR_FUNC);
  assign wr_en   = wr_stb && (addr == `ADDR_OUT_EN);
  assign comb    = tmfc_pkg::comb_mode_e'(func_ff[`COMB_HI:`COMB_LO]);
  assign combined = (comb == tmfc_pkg::comb_complementary) ||
                    (comb == tmfc_pkg::comb_reset_sync);
  assign trigger = combined && !out_ctrl_ff[`BIT_TRIG_OFF] &&
                   events.cap_a_ch1;
  assign ch2_state = mode_ff[`BIT_PHASE] ? tmfc_pkg::ph_phase
                                         : tmfc_pkg::ph_normal;

  // mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= `MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= wdata | `MODE_FIXED;
    end
  end

  // function register
  always_ff @(posedge clk) begin
    if (rst) begin
      func_ff <= `FUNC_RESET;
    end else if (wr_func) begin
      func_ff <= wdata | `FUNC_FIXED;
    end
  end

  // output enable register, trigger clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      out_en_ff <= `OUT_EN_RESET;
    end else if (trigger) begin
      out_en_ff <= `OUT_EN_FIXED;
    end else if (wr_en) begin
      out_en_ff <= wdata | `OUT_EN_FIXED;
    end
  end

  // output control and sync registers
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ctrl_ff <= `OUT_CTRL_RESET;
      sync_ff     <= `SYNC_RESET;
    end else if (wr_stb && addr == `ADDR_OUT_CTRL) begin
      out_ctrl_ff <= wdata | `OUT_CTRL_FIXED;
    end else if (wr_stb && addr == `ADDR_SYNC) begin
      sync_ff <= wdata | `SYNC_FIXED;
    end
  end

  // sync bits stay live in combined modes
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_34_ff   <= 2'h0;
      comb_mode_ff <= 2'h0;
    end else begin
      sync_34_ff   <= sync_ff[4:3];
      comb_mode_ff <= func_ff[`COMB_HI:`COMB_LO];
    end
  end

  // pwm selection, combined modes mask channels 3 and 4
  always_comb begin
    pwm_sel = mode_ff[4:0];
    if (combined) begin
      pwm_sel[4:3] = 2'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_pwm
      pwm_pin u_pwm (
        .clk      (clk),
        .resetn   (!rst),
        .enable   (pwm_sel[g]),
        .match_a  (events.gen_a_match[g]),
        .match_b  (events.gen_b_match[g]),
        .level_ff (pwm_lvl[g])
      );
    end
  endgenerate

  // pin outputs registered, pwm levels passed ungated beside the output enables
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_ff <= '0;
    end else begin
      pins_ff.pwm_pin    <= pwm_lvl;
      pins_ff.pwm_active <= pwm_sel;
      pins_ff.pin_enable <= out_en_ff[5:0];
    end
  end

  // buffer transfers, order b4 a4 b3 a3
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_to_gen_ff <= 4'h0;
      gen_to_buf_ff <= 4'h0;
    end else begin
      buf_to_gen_ff <= func_ff[3:0] & ~is_capture &
        {events.gen_b_match[4], events.gen_a_match[4],
         events.gen_b_match[3], events.gen_a_match[3]};
      gen_to_buf_ff <= func_ff[3:0] & is_capture &
        events.capture;
    end
  end

  // phase decoder input history
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_a_ff <= 1'b0;
      clk_b_ff <= 1'b0;
    end else begin
      clk_a_ff <= ext_clock_in_a;
      clk_b_ff <= ext_clock_in_b;
    end
  end

  assign edge_a = ext_clock_in_a ^ clk_a_ff;
  assign edge_b = ext_clock_in_b ^ clk_b_ff;

  // quadrature direction from the other input
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (edge_a && !edge_b) begin
      step_up = !(ext_clock_in_a ^ ext_clock_in_b);
      step_dn = ext_clock_in_a ^ ext_clock_in_b;
    end else if (edge_b && !edge_a) begin
      step_up = ext_clock_in_a ^ ext_clock_in_b;
      step_dn = !(ext_clock_in_a ^ ext_clock_in_b);
    end
  end

  // channel 2 counter step
  always_comb begin
    nxt_count = counter_ch2_ff;
    over_ev   = 1'b0;
    unf_ev    = 1'b0;
    case (ch2_state)
      tmfc_pkg::ph_phase: begin
        if (step_up) begin
          nxt_count = counter_ch2_ff + 16'h0001;
          over_ev   = (counter_ch2_ff == 16'hffff);
        end else if (step_dn) begin
          nxt_count = counter_ch2_ff - 16'h0001;
          unf_ev    = (counter_ch2_ff == 16'h0000);
        end
      end
      tmfc_pkg::ph_normal: begin
        if (counter_ch2_run) begin
          nxt_count = counter_ch2_ff + 16'h0001;
          over_ev   = (counter_ch2_ff == 16'hffff);
        end
      end
      default: begin
        nxt_count = counter_ch2_ff;
      end
    endcase
    if (events.gen_a_match[2] || events.gen_b_match[2]) begin
      nxt_count = counter_ch2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      counter_ch2_ff <= `COUNT_RESET;
    end else begin
      counter_ch2_ff <= nxt_count;
    end
  end

  // overflow flag, set wins over write-zero clear
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_ff <= 1'b0;
    end else if (over_ev || (unf_ev && !mode_ff[`BIT_FLAG_DIR])) begin
      overflow_flag_ff <= 1'b1;
    end else if (wr_stb && addr == `ADDR_STATUS && !wdata[0]) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    case (addr)
      `ADDR_MODE:     nxt_rdata = mode_ff;
      `ADDR_FUNC:     nxt_rdata = func_ff;
      `ADDR_OUT_EN:   nxt_rdata = out_en_ff;
      `ADDR_OUT_CTRL: nxt_rdata = out_ctrl_ff;
      `ADDR_SYNC:     nxt_rdata = sync_ff;
      `ADDR_COUNT_LO: nxt_rdata = counter_ch2_ff[7:0];
      `ADDR_COUNT_HI: nxt_rdata = counter_ch2_ff[15:8];
      `ADDR_STATUS:   nxt_rdata = {7'h7f, overflow_flag_ff};
      default:        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (rd_stb) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end
endmodule // timer_mode_function_control

// ---- rtl/tmfc_defs.svh ----
// constants for the timer mode and function control block
// assumes a plain register port and one 50 MHz clock
`ifndef TMFC_DEFS_SVH
`define TMFC_DEFS_SVH

`define ADDR_MODE      4'h0
`define ADDR_FUNC      4'h1
`define ADDR_OUT_EN    4'h2
`define ADDR_OUT_CTRL  4'h3
`define ADDR_SYNC      4'h4
`define ADDR_COUNT_LO  4'h5
`define ADDR_COUNT_HI  4'h6
`define ADDR_STATUS    4'h7

`define MODE_RESET     8'h80
`define MODE_FIXED     8'h80
`define FUNC_RESET     8'hc0
`define FUNC_FIXED     8'hc0
`define OUT_EN_RESET   8'hff
`define OUT_EN_FIXED   8'hc0
`define OUT_CTRL_RESET 8'hff
`define OUT_CTRL_FIXED 8'hef
`define SYNC_RESET     8'he0
`define SYNC_FIXED     8'he0

`define BIT_PHASE      6
`define BIT_FLAG_DIR   5
`define BIT_TRIG_OFF   4
`define COMB_HI        5
`define COMB_LO        4
`define COUNT_RESET    16'h0000

`endif

// ---- rtl/tmfc_pkg.sv ----
// types for the timer mode and function control block
// assumes tmfc_defs.svh supplies the numeric constants
package tmfc_pkg;
  typedef enum logic [1:0] {
    comb_normal,
    comb_normal_alt,
    comb_complementary,
    comb_reset_sync
  } comb_mode_e;

  typedef enum {
    ph_normal,
    ph_phase
  } ch2_state_e;

  typedef struct packed {
    logic [4:0] gen_a_match;
    logic [4:0] gen_b_match;
    logic [3:0] capture;
    logic       cap_a_ch1;
  } timer_events_s;

  typedef struct packed {
    logic [4:0] pwm_pin;
    logic [4:0] pwm_active;
    logic [5:0] pin_enable;
  } pin_out_s;
endpackage

// ---- testbench/quad_encoder.sv ----
// quadrature encoder model on the two clock pins
// assumes a one-cycle step pulse per edge
module quad_encoder (
  // clock and command
  input wire logic clk,
  input wire logic step,
  input wire logic up,
  // pins
  output logic     ext_clock_in_a,
  output logic     ext_clock_in_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_ff = 2'b00;
  // up walks 00 01 11 10, down the reverse
  always @(posedge clk) begin
    if (step) ph_ff <= up ? ph_ff + 2'd1 : ph_ff - 2'd1;
  end
  assign ext_clock_in_a = ph_ff[1];
  assign ext_clock_in_b = ph_ff[1] ^ ph_ff[0];
endmodule // quad_encoder

// ---- testbench/testbench.sv ----
// self-checking bench for timer_mode_function_control
// assumes package, design, monitor and encoder compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk, resetn, standby, wr_stb, rd_stb;
  logic                    run, step, up, qa, qb, oflag;
  logic [1:0]              comb, sync34;
  logic [3:0]              addr, a, ic, b2g, g2b, b2g_acc, g2b_acc;
  logic [7:0]              wdata, rdata, d;
  logic [7:0]              sh [3];
  logic [15:0]             cnt, exp_cnt;
  tmfc_pkg::timer_events_s ev;
  tmfc_pkg::pin_out_s      pins;
  int                      n_fail = 0, n_checks = 0, seed = 9;
  localparam logic [7:0] fx [3] = '{8'h80, 8'hc0, 8'hc0};
  localparam logic [7:0] tf [4] = '{8'h20, 8'h30, 8'h00, 8'h20};
  localparam logic [7:0] tt [4] = '{8'hef, 8'hef, 8'hef, 8'hff};
  localparam logic [7:0] te [4] = '{8'hc0, 8'hc0, 8'hff, 8'hff};
  timer_mode_function_control dut (.clk, .resetn, .standby, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata_ff(rdata), .events(ev), .is_capture(ic),
    .ext_clock_in_a(qa), .ext_clock_in_b(qb), .counter_ch2_run(run),
    .buf_to_gen_ff(b2g), .gen_to_buf_ff(g2b), .pins_ff(pins),
    .comb_mode_ff(comb), .sync_34_ff(sync34), .counter_ch2_ff(cnt),
    .overflow_flag_ff(oflag));
  quad_encoder enc (.clk, .step, .up, .ext_clock_in_a(qa),
    .ext_clock_in_b(qb));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    b2g_acc <= b2g_acc | b2g;
    g2b_acc <= g2b_acc | g2b;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] wa, input logic [7:0] wd);
    @(posedge clk);
    addr   <= wa;
    wdata  <= wd;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] ra, input logic [7:0] exp);
    @(posedge clk);
    addr   <= ra;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask
  task automatic fire(input tmfc_pkg::timer_events_s e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic step_enc(input logic u);
    @(posedge clk);
    step <= 1'b1;
    up   <= u;
    @(posedge clk);
    step <= 1'b0;
    exp_cnt = u ? exp_cnt + 16'd1 : exp_cnt - 16'd1;
    for (int i = 0; i < 8 && cnt !== exp_cnt; i++) @(negedge clk);
    check(cnt, exp_cnt);
    if (cnt !== exp_cnt) test_done();
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
  initial begin
    {resetn, standby, wr_stb, rd_stb, run, step, up} = '0;
    {addr, wdata, ic, ev, b2g_acc, g2b_acc, exp_cnt} = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      rdchk(4'h0, 8'h80);
      rdchk(4'h1, 8'hc0);
      rdchk(4'h2, 8'hff);
      rdchk(4'hf, 8'h00);
      wr(4'h0, 8'h7f);
      @(posedge clk) standby <= 1'b1;
      @(posedge clk) standby <= 1'b0;
    end
    $display("reset values done");
    sh = '{8'h80, 8'hc0, 8'hff};
    for (int i = 0; i < 30; i++) begin
      a = 4'(i % 3);
      d = 8'($random(seed));
      sh[a] = d | fx[a];
      wr(a, d);
      rdchk(a, sh[a]);
      check(pins.pwm_active, sh[0][4:0] & (sh[1][5] ? 5'h07 : 5'h1f));
      check(comb, sh[1][5:4]);
      check(pins.pin_enable, sh[2][5:0]);
    end
    $display("register access done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h1f);
    fire('{gen_a_match: 5'h1f, default: '0});
    check(pins.pwm_pin, 5'h1f);
    fire('{gen_b_match: 5'h1f, default: '0});
    check(pins.pwm_pin, 5'h00);
    $display("pwm done");
    for (int i = 0; i < 8; i++) begin
      d = {4'hc, 4'($random(seed))};
      @(posedge clk) ic <= 4'($random(seed));
      wr(4'h1, d);
      @(negedge clk);
      b2g_acc = '0;
      g2b_acc = '0;
      fire('{gen_a_match: 5'h18, gen_b_match: 5'h18, capture: 4'hf,
        default: '0});
      check(b2g_acc, d[3:0] & ~ic);
      check(g2b_acc, d[3:0] & ic);
    end
    $display("buffering done");
    // trigger clears enables in combined modes unless disabled, sync bits untouched
    for (int i = 0; i < 4; i++) begin
      wr(4'h2, 8'hff);
      wr(4'h1, tf[i]);
      wr(4'h3, tt[i]);
      wr(4'h4, 8'h08);
      fire('{cap_a_ch1: 1'b1, default: '0});
      check(sync34, 2'h1);
      rdchk(4'h2, te[i]);
      check(pins.pin_enable, te[i][5:0]);
    end
    $display("trigger done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h60);
    step_enc(1'b0);
    check(oflag, 1'b0);
    step_enc(1'b1);
    check(oflag, 1'b1);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h40);
    @(negedge clk);
    check(oflag, 1'b0);
    step_enc(1'b0);
    check(oflag, 1'b1);
    @(posedge clk) run <= 1'b1;
    for (int i = 0; i < 24; i++) step_enc(1'($random(seed)));
    $display("phase counting done");
    test_done();
  end
endmodule // testbench

// ---- testbench/tmfc_monitor.sv ----
// assertions on the mode and function control ports
// assumes it is bound into timer_mode_function_control
module tmfc_monitor (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    standby,
  // register port
  input wire logic [3:0]              addr,
  input wire logic [7:0]              wdata,
  input wire logic                    wr_stb,
  input wire logic                    rd_stb,
  input wire logic [7:0]              rdata_ff,
  // events and results
  input wire tmfc_pkg::timer_events_s events,
  input wire tmfc_pkg::pin_out_s      pins_ff,
  input wire logic [15:0]             counter_ch2_ff,
  input wire logic                    overflow_flag_ff
);
  logic       external_trigger_disable_ff;
  logic [1:0] comb_ff;
  // shadow of trigger disable and mode field
  always_ff @(posedge clk) begin
    if (!resetn || standby) begin
      external_trigger_disable_ff <= 1'b1;
      comb_ff <= 2'b00;
    end else if (wr_stb) begin
      if (addr == 4'h3) external_trigger_disable_ff <= wdata[4];
      if (addr == 4'h1) comb_ff <= wdata[5:4];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || standby);
  sequence a_hit;
    events.gen_a_match[0] && !events.gen_b_match[0] && pins_ff.pwm_active[0]
    ##1 !events.gen_b_match[0] && pins_ff.pwm_active[0];
  endsequence
  sequence b_hit;
    events.gen_b_match[0] && pins_ff.pwm_active[0]
    ##1 !events.gen_a_match[0] && pins_ff.pwm_active[0];
  endsequence
  sequence trig_on;
    events.cap_a_ch1 && comb_ff[1] && !external_trigger_disable_ff ##1 !wr_stb;
  endsequence
  property rd_fix(a, m);
    $past(rd_stb) && $past(addr) == a |-> (rdata_ff & m) == m;
  endproperty
  chk_mode_fixed: assert property (rd_fix(4'h0, 8'h80))
    else $error("mode bit 7 not one");
  chk_func_fixed: assert property (rd_fix(4'h1, 8'hc0))
    else $error("function bits 7:6 not one");
  chk_oen_fixed: assert property (rd_fix(4'h2, 8'hc0))
    else $error("enable bits 7:6 not one");
  chk_pwm_rise: assert property (a_hit |-> ##[0:1] pins_ff.pwm_pin[0])
    else $error("pwm pin not set");
  chk_pwm_fall: assert property (b_hit |-> ##[0:1] !pins_ff.pwm_pin[0])
    else $error("pwm pin not cleared");
  chk_comb_wins: assert property (comb_ff[1] && $past(comb_ff[1])
    |-> pins_ff.pwm_active[4:3] == 2'b00) else $error("pwm bits not ignored");
  chk_trig_clear: assert property (trig_on
    |-> ##[0:1] pins_ff.pin_enable == 6'h00) else $error("enables kept");
  chk_over_sets: assert property ($past(counter_ch2_ff) == 16'hffff
    && counter_ch2_ff == 16'h0000 |-> ##[0:1] overflow_flag_ff)
    else $error("overflow flag not set");
endmodule // tmfc_monitor
bind timer_mode_function_control tmfc_monitor mon (.clk, .resetn, .standby,
  .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff, .events, .pins_ff,
  .counter_ch2_ff, .overflow_flag_ff);
